// ---- core/octal_switch_consts.svh ----
/*
 Constants of the octal switch serial control: word size, counters,
 reset values and start-up timing.
 Assumes the core clock period given here matches CORE_CLK.
*/
`ifndef OCTAL_SWITCH_CONSTS_SVH
`define OCTAL_SWITCH_CONSTS_SVH

`define OSW_WORD_BITS      8
`define OSW_CNT_BITS       3
`define OSW_INVALID_LIMIT  4
`define OSW_INVALID_BITS   3
`define OSW_SYNC_STAGES    2
`define OSW_CLK_PERIOD_NS  4
`define OSW_STARTUP_NS     1000
`define OSW_STARTUP_CYC    ((`OSW_STARTUP_NS + `OSW_CLK_PERIOD_NS - 1) / `OSW_CLK_PERIOD_NS)
`define OSW_STARTUP_BITS   16
`define OSW_WORD_RST       8'h00
`define OSW_CNT_RST        3'h0

`endif

// ---- core/osw_pkg.sv ----
/*
 Types shared by the octal switch serial control.
 Assumes octal_switch_consts.svh is on the include path.
*/
`include "octal_switch_consts.svh"

package osw_pkg;

   typedef logic [`OSW_WORD_BITS-1:0] chan_word_t;

   // Serial link pins as seen at the device
   typedef struct packed
   {
      logic cs_n;
      logic sclk;
      logic din;
   } ser_pins_t;

   // Output-side status returned across the barrier
   typedef struct packed
   {
      chan_word_t overtemp;
      logic       supply_low;
   } drv_status_t;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b001,
      ST_SHIFT  = 3'b010,
      ST_COMMIT = 3'b100
   } link_state_t;

endpackage : osw_pkg

// ---- core/osw_sync.sv ----
/*
 Two-flop synchroniser for a vector of asynchronous levels.
 Assumes each bit is an independent level; no bus coherency is implied.
*/
`timescale 1ns/1ns
`default_nettype none

module osw_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk,    // Core clock
   input  wire logic             rst,    // Synchronous reset, high
   input  wire logic             ce,     // Clock enable
   input  wire logic [WIDTH-1:0] rst_val, // Value held during reset
   input  wire logic [WIDTH-1:0] d,      // Asynchronous input
   output logic      [WIDTH-1:0] q       // Synchronised output
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_r <= rst_val;
         q      <= rst_val;
      end
      else if (ce)
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : osw_sync

`default_nettype wire

// ---- core/octal_switch_serial_ctrl.sv ----
/*
 Serial control logic of an eight-channel isolated high-side switch:
 shift register, clock modulo counter, channel latches, disable,
 transfer failure blanking, start-up hold and common alert pin.
 Assumes all link pins and output-side status are asynchronous to
 CORE_CLK, which runs much faster than the serial clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "octal_switch_consts.svh"

// Contract
// - Eight output channels, each switched by serially received data.
// - Each channel has its own latch; the kill input clears all of them.
// - Bit one switches the channel on, bit zero switches it off.
// - Kill input low switches every channel off at once.
// - While kill is low, input shift register and latches are cleared.
// - After kill releases, channels stay off until a new word arrives.
// - Serial interface works only while chip select is low.
// - Data input is sampled on each serial clock rising edge.
// - Data output changes after each serial clock falling edge.
// - Data output driven only while chip select low, else released.
// - Data output carries the shifted register content for daisy chains.
// - Chip select rising copies shifted bits into channel latches.
// - Alert output is the OR of the per-channel overtemperature detectors and the low supply flag.
// - Alert high normally, low on overtemperature or low driver supply.
// - Output stage stays disabled until interface is stable after power-up.
// - Clock pulses counted; word accepted only for whole multiples of eight.
// - Words travel most significant bit first on input and output.
// - Four invalid transfers in a row switch all channels off.
module octal_switch_serial_ctrl
   import osw_pkg::*;
#(
   parameter int WORD_BITS      = `OSW_WORD_BITS,
   parameter int INVALID_LIMIT  = `OSW_INVALID_LIMIT,
   parameter int STARTUP_CYCLES = `OSW_STARTUP_CYC
)
(
   input  wire logic                CORE_CLK,           // Core clock, 250 MHz
   input  wire logic                SYS_RST,            // Synchronous reset, high
   input  wire logic                CLK_EN,             // Clock enable, low freezes all
   input  wire osw_pkg::ser_pins_t  SER_PINS,           // Chip select, clock, data in
   input  wire logic                OUTPUT_KILL_N,      // Disable all channels, low
   input  wire osw_pkg::drv_status_t DRV_STATUS,        // Overtemp and supply flags
   output logic                     SER_DOUT,           // Serial data out value
   output logic                     SER_DOUT_OE,        // Serial data out enable
   output osw_pkg::chan_word_t      CHANNEL_DRIVE,      // Channel on commands
   output logic                     OVERTEMP_ALERT_N_O, // Alert pin value, always 0
   output logic                     OVERTEMP_ALERT_N_OE // Alert pin pulls low
);

   import osw_pkg::*;

   localparam logic [2:0] PIN_RST = 3'h6;
   localparam int         STAT_W  = WORD_BITS + 1;
   localparam logic [`OSW_STARTUP_BITS-1:0] STARTUP_LAST =
      `OSW_STARTUP_BITS'(STARTUP_CYCLES - 1);
   localparam logic [`OSW_INVALID_BITS-1:0] INVALID_MAX =
      `OSW_INVALID_BITS'(INVALID_LIMIT);

   ser_pins_t         pins_s;
   logic              kill_n_s;
   drv_status_t       stat_s;
   logic [2:0]        pins_raw;
   logic [2:0]        pins_q;
   logic [0:0]        kill_q;
   logic [STAT_W-1:0] stat_q;

   logic              sclk_d_r;
   logic              sclk_rise;
   logic              sclk_fall;
   logic              cs_d_r;
   logic              cs_fall;
   logic              cs_rise;

   link_state_t       state_r;
   link_state_t       state_nxt;

   chan_word_t        shift_r;
   logic [`OSW_CNT_BITS-1:0] clk_cnt_r;
   logic              any_clk_r;
   logic              word_ok;

   chan_word_t        latch_r;
   logic [`OSW_INVALID_BITS-1:0] invalid_cnt_r;
   logic              blank_r;
   logic [`OSW_STARTUP_BITS-1:0] startup_cnt_r;
   logic              stage_en_r;

   // Pin inputs pass two flip-flops before any logic reads them
   assign pins_raw = {SER_PINS.cs_n, SER_PINS.sclk, SER_PINS.din};

   osw_sync #(.WIDTH(3)) u_pin_sync
   (
      .clk     (CORE_CLK),
      .rst     (SYS_RST),
      .ce      (CLK_EN),
      .rst_val (PIN_RST),
      .d       (pins_raw),
      .q       (pins_q)
   );

   osw_sync #(.WIDTH(1)) u_kill_sync
   (
      .clk     (CORE_CLK),
      .rst     (SYS_RST),
      .ce      (CLK_EN),
      .rst_val (1'h0),
      .d       (OUTPUT_KILL_N),
      .q       (kill_q)
   );

   osw_sync #(.WIDTH(STAT_W)) u_stat_sync
   (
      .clk     (CORE_CLK),
      .rst     (SYS_RST),
      .ce      (CLK_EN),
      .rst_val ({STAT_W{1'b0}}),
      .d       (DRV_STATUS),
      .q       (stat_q)
   );

   assign pins_s   = ser_pins_t'(pins_q);
   assign kill_n_s = kill_q[0];
   assign stat_s   = drv_status_t'(stat_q);

   // Edge detection on the synchronised serial clock and chip select
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         sclk_d_r <= 1'b1;
         cs_d_r   <= 1'b1;
      end
      else if (CLK_EN)
      begin
         sclk_d_r <= pins_s.sclk;
         cs_d_r   <= pins_s.cs_n;
      end
   end

   assign sclk_rise = pins_s.sclk & ~sclk_d_r;
   assign sclk_fall = ~pins_s.sclk & sclk_d_r;
   assign cs_fall   = ~pins_s.cs_n & cs_d_r;
   assign cs_rise   = pins_s.cs_n & ~cs_d_r;

   // Link sequencing: idle, shifting, one-cycle commit
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (cs_fall)
               state_nxt = ST_SHIFT;
         end
         ST_SHIFT:
         begin
            if (cs_rise)
               state_nxt = ST_COMMIT;
         end
         ST_COMMIT:
         begin
            state_nxt = ST_IDLE;
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
         state_r <= ST_IDLE;
      else if (CLK_EN)
         state_r <= state_nxt;
   end

   // Shift register and modulo clock counter
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         shift_r   <= `OSW_WORD_RST;
         clk_cnt_r <= `OSW_CNT_RST;
         any_clk_r <= 1'b0;
      end
      else if (CLK_EN)
      begin
         if (!kill_n_s)
         begin
            shift_r   <= `OSW_WORD_RST;
            clk_cnt_r <= `OSW_CNT_RST;
            any_clk_r <= 1'b0;
         end
         else if (cs_fall)
         begin
            clk_cnt_r <= `OSW_CNT_RST;
            any_clk_r <= 1'b0;
         end
         else if (state_r == ST_SHIFT && sclk_rise)
         begin
            shift_r   <= {shift_r[WORD_BITS-2:0], pins_s.din};
            clk_cnt_r <= clk_cnt_r + `OSW_CNT_BITS'(1);
            any_clk_r <= 1'b1;
         end
      end
   end

   // A word counts only for a non-empty whole multiple of eight clocks
   assign word_ok = any_clk_r && (clk_cnt_r == `OSW_CNT_RST);

   // Serial data output: MSB of shift register, moved on falling clock
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         SER_DOUT    <= 1'b0;
         SER_DOUT_OE <= 1'b0;
      end
      else if (CLK_EN)
      begin
         if (cs_fall)
         begin
            SER_DOUT    <= shift_r[WORD_BITS-1];
            SER_DOUT_OE <= 1'b1;
         end
         else if (pins_s.cs_n)
         begin
            SER_DOUT_OE <= 1'b0;
         end
         else if (sclk_fall)
         begin
            SER_DOUT <= shift_r[WORD_BITS-1];
         end
      end
   end

   // Channel latches and invalid transfer counter
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         latch_r       <= `OSW_WORD_RST;
         invalid_cnt_r <= '0;
         blank_r       <= 1'b0;
      end
      else if (CLK_EN)
      begin
         if (!kill_n_s)
         begin
            latch_r       <= `OSW_WORD_RST;
            invalid_cnt_r <= '0;
            blank_r       <= 1'b0;
         end
         else if (state_r == ST_COMMIT)
         begin
            if (word_ok)
            begin
               latch_r       <= shift_r;
               invalid_cnt_r <= '0;
               blank_r       <= 1'b0;
            end
            else if (invalid_cnt_r >= INVALID_MAX - 1'b1)
            begin
               invalid_cnt_r <= INVALID_MAX;
               blank_r       <= 1'b1;
            end
            else
            begin
               invalid_cnt_r <= invalid_cnt_r + 1'b1;
            end
         end
      end
   end

   // Start-up hold of the output stage
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         startup_cnt_r <= '0;
         stage_en_r    <= 1'b0;
      end
      else if (CLK_EN && !stage_en_r)
      begin
         if (startup_cnt_r == STARTUP_LAST)
            stage_en_r <= 1'b1;
         else
            startup_cnt_r <= startup_cnt_r + 1'b1;
      end
   end

   // One drive flop per channel
   genvar ch;
   generate
      for (ch = 0; ch < WORD_BITS; ch++)
      begin : g_chan
         always_ff @(posedge CORE_CLK)
         begin
            if (SYS_RST)
               CHANNEL_DRIVE[ch] <= 1'b0;
            else if (CLK_EN)
               CHANNEL_DRIVE[ch] <= latch_r[ch] & kill_n_s
                                    & stage_en_r & ~blank_r;
         end
      end
   endgenerate

   // Common alert, open drain: enable pulls the pin low
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         OVERTEMP_ALERT_N_O  <= 1'b0;
         OVERTEMP_ALERT_N_OE <= 1'b0;
      end
      else if (CLK_EN)
      begin
         OVERTEMP_ALERT_N_O  <= 1'b0;
         OVERTEMP_ALERT_N_OE <= (|stat_s.overtemp)
                                | stat_s.supply_low;
      end
   end

endmodule : octal_switch_serial_ctrl

`default_nettype wire

// ---- verification/osw_properties.sv ----
/*
 Checker for the octal switch serial control, bound to its top module.
 Assumes link pins toggle slowly against CORE_CLK; checks pause while
 CLK_EN is low, since the design then holds all of its state.
*/
`timescale 1ns/1ns
`default_nettype none

module osw_checker
(
   input wire logic                 CORE_CLK,            // Core clock
   input wire logic                 SYS_RST,             // Reset, high
   input wire logic                 CLK_EN,              // Clock enable
   input wire osw_pkg::ser_pins_t   SER_PINS,            // Link pins
   input wire logic                 OUTPUT_KILL_N,       // Kill, low
   input wire osw_pkg::drv_status_t DRV_STATUS,          // Fault flags
   input wire logic                 SER_DOUT,            // Serial out
   input wire logic                 SER_DOUT_OE,         // Serial out enable
   input wire osw_pkg::chan_word_t  CHANNEL_DRIVE,       // Channel commands
   input wire logic                 OVERTEMP_ALERT_N_O,  // Alert value
   input wire logic                 OVERTEMP_ALERT_N_OE  // Alert enable
);
   import osw_pkg::*;

   logic [3:0] cs_hi_r;

   // Cycles since chip select went high, saturating
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST || !SER_PINS.cs_n)
         cs_hi_r <= 4'h0;
      else if (cs_hi_r != 4'hF)
         cs_hi_r <= cs_hi_r + 4'h1;
   end

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST || !CLK_EN);

   property p_kill_off;
      (!OUTPUT_KILL_N)[*4] |-> CHANNEL_DRIVE == 8'h00;
   endproperty
   a_kill_off: assert property (p_kill_off)
      else $error("Channels on while kill held");
   property p_oe_idle;
      (SER_PINS.cs_n)[*6] |-> !SER_DOUT_OE;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("Serial out driven while deselected");
   property p_oe_active;
      (!SER_PINS.cs_n)[*6] |-> SER_DOUT_OE;
   endproperty
   a_oe_active: assert property (p_oe_active)
      else $error("Serial out not driven while selected");
   property p_dout_hold;
      !SER_PINS.sclk ##1 (SER_PINS.sclk && !SER_PINS.cs_n)[*8]
         |-> $past(SER_DOUT, 7) == SER_DOUT;
   endproperty
   a_dout_hold: assert property (p_dout_hold)
      else $error("Serial out moved while clock high");
   property p_alert_on;
      (DRV_STATUS != 9'h000)[*4] |-> OVERTEMP_ALERT_N_OE;
   endproperty
   a_alert_on: assert property (p_alert_on)
      else $error("Alert missing on fault");
   property p_alert_off;
      (DRV_STATUS == 9'h000)[*4] |-> !OVERTEMP_ALERT_N_OE;
   endproperty
   a_alert_off: assert property (p_alert_off)
      else $error("Alert without fault");
   property p_alert_val;
      !OVERTEMP_ALERT_N_O;
   endproperty
   a_alert_val: assert property (p_alert_val)
      else $error("Alert pin value not low");
   property p_commit;
      $changed(CHANNEL_DRIVE) && CHANNEL_DRIVE != 8'h00
         |-> cs_hi_r inside {[4'h3:4'h9]};
   endproperty
   a_commit: assert property (p_commit)
      else $error("Channels changed away from select release");
endmodule : osw_checker

bind octal_switch_serial_ctrl osw_checker u_chk (.CORE_CLK, .SYS_RST, .CLK_EN, .SER_PINS,
   .OUTPUT_KILL_N, .DRV_STATUS, .SER_DOUT, .SER_DOUT_OE, .CHANNEL_DRIVE,
   .OVERTEMP_ALERT_N_O, .OVERTEMP_ALERT_N_OE);

`default_nettype wire

// ---- verification/osw_master.sv ----
/*
 Serial master model: frames of n link clocks, 64 ns period, MSB first.
 Assumes clk is the core clock; pins change 1 ns after its rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module osw_master
(
   input  wire logic              clk,  // Core clock
   input  wire logic              dout, // Device serial out
   input  wire logic              oe,   // Device serial out enable
   output var osw_pkg::ser_pins_t pins  // Select, clock, data
);
   import osw_pkg::*;

   // Idle: deselected, clock high, data at its pull-down level
   initial pins = '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // Clock pulses with chip select high; the device must ignore them
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++)
      begin
         tick(8);
         pins.sclk = 1'b0;
         pins.din  = 1'b1;
         tick(8);
         pins.sclk = 1'b1;
      end
      pins.din = 1'b0;
   endtask : idle_clocks

   task automatic frame(input logic [15:0] w, input int n, output logic [15:0] so);
      so = 16'h0000;
      tick(1);
      pins.cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         tick(8);
         pins.sclk = 1'b0;
         pins.din  = w[i];
         tick(8);
         pins.sclk = 1'b1;
         so = {so[14:0], oe ? dout : 1'bx};
      end
      tick(8);
      pins.cs_n = 1'b1;
      pins.din  = 1'b0;
   endtask : frame
endmodule : osw_master

`default_nettype wire

// ---- verification/tb_octal_switch_serial_ctrl.sv ----
/*
 Self-checking bench for the octal switch serial control.
 Assumes the serial master model and the bound checker are compiled.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_octal_switch_serial_ctrl;
   import osw_pkg::*;

   logic        clk;
   logic        rst;
   logic        clk_en;
   logic        kill_n;
   ser_pins_t   pins;
   drv_status_t status;
   logic        dout;
   logic        dout_oe;
   logic        alert_o;
   logic        alert_oe;
   chan_word_t  drive;
   logic [15:0] so;
   int          miscompares = 0;
   int          num_checks = 0;

   octal_switch_serial_ctrl #(.STARTUP_CYCLES(400)) DUT (.CORE_CLK(clk), .SYS_RST(rst),
      .CLK_EN(clk_en), .SER_PINS(pins), .OUTPUT_KILL_N(kill_n), .DRV_STATUS(status),
      .SER_DOUT(dout), .SER_DOUT_OE(dout_oe), .CHANNEL_DRIVE(drive),
      .OVERTEMP_ALERT_N_O(alert_o), .OVERTEMP_ALERT_N_OE(alert_oe));

   osw_master u_master (.clk(clk), .dout(dout), .oe(dout_oe), .pins(pins));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   // One frame, then time for the latch update after select release
   task automatic send(input logic [15:0] w, input int n);
      u_master.frame(w, n, so);
      u_master.tick(10);
   endtask : send

   // Word taken during the start-up hold must not reach the channels
   task automatic t_startup;
      send(16'h003C, 8);
      chk("held drive", drive, 16'h0000);
      kill_n = 1'b0;
      u_master.tick(5);
      kill_n = 1'b1;
      u_master.tick(250);
      chk("drive", drive, 16'h0000);
   endtask : t_startup

   task automatic t_basic;
      send(16'h00A5, 8);
      chk("reset shift out", so, 16'h0000);
      chk("drive", drive, 16'h00A5);
      chk("out enable", dout_oe, 16'h0000);
   endtask : t_basic

   task automatic t_daisy;
      send(16'h12C3, 16);
      chk("chain out", so, 16'hA512);
      chk("drive", drive, 16'h00C3);
   endtask : t_daisy

   task automatic t_invalid;
      int cnt[4] = '{7, 9, 0, 15};
      for (int i = 0; i < 4; i++)
      begin
         send(16'h00FF, cnt[i]);
         chk("drive", drive, (i < 3) ? 16'h00C3 : 16'h0000);
      end
      send(16'h005A, 8);
      chk("drive", drive, 16'h005A);
   endtask : t_invalid

   task automatic t_kill;
      kill_n = 1'b0;
      u_master.tick(5);
      chk("drive", drive, 16'h0000);
      kill_n = 1'b1;
      u_master.tick(5);
      chk("drive", drive, 16'h0000);
      send(16'h0081, 8);
      chk("cleared shift", so, 16'h0000);
      chk("drive", drive, 16'h0081);
      u_master.idle_clocks(4);
      send(16'h0018, 8);
      chk("idle shift", so, 16'h0081);
      chk("drive", drive, 16'h0018);
   endtask : t_kill

   // Clock enable low freezes synchronisers, latches and drives
   task automatic t_freeze;
      clk_en = 1'b0;
      kill_n = 1'b0;
      status = 9'h080;
      u_master.tick(6);
      chk("frozen drive", drive, 16'h0018);
      chk("frozen alert", alert_oe, 16'h0000);
      clk_en = 1'b1;
      u_master.tick(5);
      chk("drive", drive, 16'h0000);
      chk("alert oe", alert_oe, 16'h0001);
      kill_n = 1'b1;
      status = 9'h000;
      u_master.tick(5);
      chk("alert oe", alert_oe, 16'h0000);
   endtask : t_freeze

   task automatic t_alert;
      for (int i = 0; i < 9; i++)
      begin
         status = drv_status_t'(9'h001 << i);
         u_master.tick(5);
         chk("alert oe", alert_oe, 16'h0001);
         status = 9'h000;
         u_master.tick(5);
         chk("alert oe", alert_oe, 16'h0000);
      end
      chk("alert value", alert_o, 16'h0000);
   endtask : t_alert

   initial
   begin
      rst = 1'b1;
      clk_en = 1'b1;
      kill_n = 1'b1;
      status = 9'h000;
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      u_master.tick(8);
      chk("drive", drive, 16'h0000);
      t_startup();
      t_basic();
      t_daisy();
      t_invalid();
      t_kill();
      t_alert();
      t_freeze();
      close_out();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("Run stopped by watchdog");
      close_out();
   end
endmodule : tb_octal_switch_serial_ctrl

`default_nettype wire
